// file: shared/htpc_defs.vh
// Purpose: Constants of the timer channel
// Assumes: 10 MHz pclk
// Notes:   Offsets are byte addresses
`ifndef HTPC_DEFS_VH
`define HTPC_DEFS_VH
// ==========================================
// Register offsets
`define HTPC_CTRL_OFS     12'h000
`define HTPC_COUNT_OFS    12'h004
`define HTPC_REPC_OFS     12'h008
`define HTPC_CMD_OFS      12'h00C
`define HTPC_STAT_OFS     12'h010
`define HTPC_CIDX_OFS     12'h014
`define HTPC_CDAT_OFS     12'h018
// ==========================================
// Control fields
`define HTPC_C_MODE       1:0
`define HTPC_C_UNIT       2
`define HTPC_C_OD         3
`define HTPC_C_INV        4
`define HTPC_C_CEDGE      6:5
`define HTPC_C_TSRC       8:7
`define HTPC_C_TEDGE      10:9
`define HTPC_CTRL_RST     11'h000
// Command bits
`define HTPC_K_START      0
`define HTPC_K_STOP       1
`define HTPC_K_LOW        2
`define HTPC_K_HIGH       3
`define HTPC_K_RESET      4
`define HTPC_K_CLRERR     5
// Encodings
`define HTPC_MODE_PWM     2'h1
`define HTPC_MODE_CAP     2'h2
`define HTPC_EDGE_RISE    2'h1
`define HTPC_EDGE_FALL    2'h2
`define HTPC_SRC_NONE     2'h0
`define HTPC_SRC_FIRST    2'h1
`define HTPC_SRC_PIN      2'h2
// ==========================================
// Limits
`define HTPC_DUR_MIN      15'h0001
`define HTPC_DUR_MAX      15'h7FFB
`define HTPC_SUM_MAX      16'h7FFC
`define HTPC_CNT_MAX      15'h7FFC
`define HTPC_REPC_MAX     7'h40
// Timing
`define HTPC_CLK_NS       100
`define HTPC_US_NS        1000
`define HTPC_MS_NS        1000000
// Clock cycles per tick, US_NS and MS_NS over CLK_NS
`define HTPC_US_CYC       14'h000A
`define HTPC_MS_CYC       14'h2710
`endif

// file: src/htpc_timer.v
// Purpose: One timer channel, PWM output and capture, APB slave
// Assumes: 10 MHz pclk, async active-low reset, pready always high
// Notes:   Capture memory holds 64 entries of 15 bits
//
// Notes on behaviour
// - PWM drives endless low/high rectangular cycles
// - Low then high duration in ticks
// - Durations 1..32763, sum 2..32764
// - Durations loaded only while stopped
// - Duty low over sum, period is sum
// - Force low/high sets pin at once, except in capture mode
// - Inversion flips forced levels too
// - Push-pull or open-drain, push-pull default
// - Inversion complements waveform, off after reset
// - Armed channel starts with first channel
// - Capture count on rise, fall or both
// - Repeat 0..64, zero means 64
// - Pin start trigger edge, default both
// - No trigger after reset, start runs at once
// - Trigger starts counter; first channel, pin, none
// - Third channel lacks pin trigger
// - Captures read by index 0..64, default 0
// - Stop capturing past 32764 ticks
// - Report running, unit, remaining repeats
`timescale 1ns/1ps
`include "htpc_defs.vh"
`default_nettype none

module htpc_timer #(
    parameter        IS_THIRD = 0,
    parameter [13:0] MS_DIV   = `HTPC_MS_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        first_start,
    input  wire        pin_in,
    output wire        pin_out,
    output wire        pin_oe
);

// ==========================================
// Declarations
// Idle stopped, arm waits for trigger, run counts
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_ARM  = 2'h1;
localparam [1:0] ST_RUN  = 2'h2;
localparam [13:0] US_DIV = `HTPC_US_CYC;

reg  [10:0] ctrl_reg;      // Mode and options
reg  [14:0] low_reg;       // Low duration
reg  [14:0] high_reg;      // High duration
reg  [6:0]  repc_reg;      // Repeat setting
reg  [6:0]  cidx_reg;      // Read index
reg  [1:0]  st_reg;        // Channel state
reg  [13:0] pre_reg;       // Prescaler
reg  [14:0] cnt_reg;       // Tick counter
reg         lvl_reg;       // Normal pin level
reg         drv_reg;       // Pin driven
reg  [6:0]  rem_reg;       // Captures left
reg  [6:0]  wp_reg;        // Captures taken
reg         err_reg;       // Sticky error
reg         s1_reg;        // Sync stage 1
reg         s2_reg;        // Sync stage 2
reg         s3_reg;        // Sync stage 3
reg         pl_reg;        // Filtered pin
reg  [31:0] rd_reg;        // Read data
reg  [14:0] mem [0:63];    // Captured values

// APB decode, writes land in the access phase
wire        acc    = psel & penable;
wire        wr     = acc & pwrite;
wire        rd     = acc & ~pwrite;
wire [1:0]  mode   = ctrl_reg[`HTPC_C_MODE];
wire [1:0]  tsrc   = ctrl_reg[`HTPC_C_TSRC];
wire        inv    = ctrl_reg[`HTPC_C_INV];
wire        od     = ctrl_reg[`HTPC_C_OD];
wire        run    = (st_reg == ST_RUN);
wire        stop_d = (st_reg == ST_IDLE);
wire [13:0] div    = ctrl_reg[`HTPC_C_UNIT] ? MS_DIV : US_DIV;
wire        tick   = run & (pre_reg == div - 14'h0001);
wire        rise   = ~pl_reg & s3_reg & (s2_reg == s3_reg);
wire        fall   = pl_reg & ~s3_reg & (s2_reg == s3_reg);
wire        sel_c  = (paddr == `HTPC_CTRL_OFS);
wire        sel_n  = (paddr == `HTPC_COUNT_OFS);
wire        sel_r  = (paddr == `HTPC_REPC_OFS);
wire        sel_k  = (paddr == `HTPC_CMD_OFS);
wire        sel_s  = (paddr == `HTPC_STAT_OFS);
wire        sel_i  = (paddr == `HTPC_CIDX_OFS);
wire        sel_d  = (paddr == `HTPC_CDAT_OFS);
wire        mapped = sel_c | sel_n | sel_r | sel_k | sel_s | sel_i | sel_d;
wire        k_go   = wr & sel_k & pwdata[`HTPC_K_START];
wire        k_stp  = wr & sel_k & pwdata[`HTPC_K_STOP];
wire        k_lo   = wr & sel_k & pwdata[`HTPC_K_LOW];
wire        k_hi   = wr & sel_k & pwdata[`HTPC_K_HIGH];
wire        k_rst  = wr & sel_k & pwdata[`HTPC_K_RESET];
wire        k_ce   = wr & sel_k & pwdata[`HTPC_K_CLRERR];
wire [14:0] n_lo   = pwdata[14:0];
wire [14:0] n_hi   = pwdata[30:16];
wire [15:0] n_sum  = {1'b0, n_lo} + {1'b0, n_hi};

// ==========================================
// Edge selection, zero code means both edges
function edge_hit;
    input [1:0] sel;
    input       r;
    input       f;
    begin
        case (sel)
            `HTPC_EDGE_RISE: edge_hit = r;
            `HTPC_EDGE_FALL: edge_hit = f;
            default:         edge_hit = r | f;
        endcase
    end
endfunction

wire trig_pin = (tsrc == `HTPC_SRC_PIN) & edge_hit(ctrl_reg[`HTPC_C_TEDGE], rise, fall);
wire cap_hit  = run & (mode == `HTPC_MODE_CAP) & edge_hit(ctrl_reg[`HTPC_C_CEDGE], rise, fall);
wire trig     = (st_reg == ST_ARM) & (trig_pin | ((tsrc == `HTPC_SRC_FIRST) & first_start));
wire wr_bad   = wr & ~mapped;

// Bad write checks
// Refused writes show only in the sticky error bit, unmapped ones in pslverr too; CTRL fields held while running show nowhere
wire cnt_bad  = (n_lo < `HTPC_DUR_MIN) | (n_lo > `HTPC_DUR_MAX) | (n_hi < `HTPC_DUR_MIN)
              | (n_hi > `HTPC_DUR_MAX) | (n_sum > `HTPC_SUM_MAX);
wire src_bad  = (pwdata[8:7] == 2'h3) | ((IS_THIRD != 0) & (pwdata[8:7] == `HTPC_SRC_PIN));
wire err_set  = (wr & sel_n & (~stop_d | cnt_bad))
              | (wr & sel_r & (pwdata[6:0] > `HTPC_REPC_MAX))
              | (wr & sel_c & stop_d & src_bad)
              | (wr & sel_i & (pwdata[6:0] > `HTPC_REPC_MAX));

// ==========================================
// Pin input synchroniser and filter
// Stages reset low while an idle pin may sit high; the
// false edge that follows lands while the channel is idle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        pl_reg <= 1'b0;
    end else begin
        s1_reg <= pin_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        // Accept once stages 2 and 3 agree
        if (s2_reg == s3_reg) begin
            pl_reg <= s3_reg;
        end
    end
end

// ==========================================
// Configuration registers
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_reg <= `HTPC_CTRL_RST;
        low_reg  <= `HTPC_DUR_MIN;
        high_reg <= `HTPC_DUR_MIN;
        repc_reg <= 7'h00;
        cidx_reg <= 7'h00;
    end else if (k_rst) begin
        ctrl_reg <= `HTPC_CTRL_RST;
        low_reg  <= `HTPC_DUR_MIN;
        high_reg <= `HTPC_DUR_MIN;
        repc_reg <= 7'h00;
        cidx_reg <= 7'h00;
    end else begin
        if (wr & sel_c) begin
            ctrl_reg[`HTPC_C_OD]  <= pwdata[`HTPC_C_OD];
            ctrl_reg[`HTPC_C_INV] <= pwdata[`HTPC_C_INV];
            if (stop_d & ~src_bad) begin
                ctrl_reg[`HTPC_C_MODE]  <= pwdata[`HTPC_C_MODE];
                ctrl_reg[`HTPC_C_UNIT]  <= pwdata[`HTPC_C_UNIT];
                ctrl_reg[`HTPC_C_CEDGE] <= pwdata[`HTPC_C_CEDGE];
                ctrl_reg[`HTPC_C_TSRC]  <= pwdata[`HTPC_C_TSRC];
                ctrl_reg[`HTPC_C_TEDGE] <= pwdata[`HTPC_C_TEDGE];
            end
        end
        if (wr & sel_n & stop_d & ~cnt_bad) begin
            low_reg  <= n_lo;
            high_reg <= n_hi;
        end
        if (wr & sel_r & (pwdata[6:0] <= `HTPC_REPC_MAX)) begin
            repc_reg <= pwdata[6:0];
        end
        if (wr & sel_i & (pwdata[6:0] <= `HTPC_REPC_MAX)) begin
            cidx_reg <= pwdata[6:0];
        end
    end
end

// ==========================================
// Sticky error, set wins over clear
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        err_reg <= 1'b0;
    end else if (err_set | wr_bad) begin
        err_reg <= 1'b1;
    end else if (k_ce | k_rst) begin
        err_reg <= 1'b0;
    end
end

// ==========================================
// Channel state machine and counters
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        st_reg  <= ST_IDLE;
        pre_reg <= 14'h0000;
        cnt_reg <= 15'h0000;
        lvl_reg <= 1'b0;
        drv_reg <= 1'b0;
        rem_reg <= 7'h00;
        wp_reg  <= 7'h00;
    end else if (k_rst) begin
        st_reg  <= ST_IDLE;
        pre_reg <= 14'h0000;
        cnt_reg <= 15'h0000;
        lvl_reg <= 1'b0;
        drv_reg <= 1'b0;
        rem_reg <= 7'h00;
        wp_reg  <= 7'h00;
    end else begin
        // prescaler
        // Held at zero unless running, first tick a full unit after start
        pre_reg <= (~run | tick) ? 14'h0000 : pre_reg + 14'h0001;
        if (k_lo | k_hi) begin
            lvl_reg <= k_hi;
            drv_reg <= 1'b1;
        end
        case (st_reg)
            ST_IDLE: begin
                if (k_go & (mode != 2'h0)) begin
                    cnt_reg <= 15'h0000;
                    wp_reg  <= 7'h00;
                    rem_reg <= (repc_reg == 7'h00) ? `HTPC_REPC_MAX : repc_reg;
                    // no source runs at once, else armed
                    st_reg  <= (tsrc == `HTPC_SRC_NONE) ? ST_RUN : ST_ARM;
                    // PWM always opens with its low part
                    if ((tsrc == `HTPC_SRC_NONE) & (mode == `HTPC_MODE_PWM)) begin
                        lvl_reg <= 1'b0;
                        drv_reg <= 1'b1;
                    end
                end
            end
            ST_ARM: begin
                if (k_stp) begin
                    st_reg <= ST_IDLE;
                end else if (trig) begin
                    st_reg  <= ST_RUN;
                    cnt_reg <= 15'h0000;
                    if (mode == `HTPC_MODE_PWM) begin
                        lvl_reg <= 1'b0;
                        drv_reg <= 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (k_stp) begin
                    st_reg <= ST_IDLE;
                end else if (mode == `HTPC_MODE_PWM) begin
                    if (tick) begin
                        if (cnt_reg + 15'h0001 == (lvl_reg ? high_reg : low_reg)) begin
                            cnt_reg <= 15'h0000;
                            lvl_reg <= ~lvl_reg;
                        end else begin
                            cnt_reg <= cnt_reg + 15'h0001;
                        end
                    end
                end else begin
                    if (cap_hit) begin
                        wp_reg  <= wp_reg + 7'h01;
                        rem_reg <= rem_reg - 7'h01;
                        // Last capture ends the run
                        if (rem_reg == 7'h01) begin
                            st_reg <= ST_IDLE;
                        end
                    end
                    if (tick) begin
                        if (cnt_reg == `HTPC_CNT_MAX) begin
                            st_reg <= ST_IDLE;
                        end else begin
                            cnt_reg <= cnt_reg + 15'h0001;
                        end
                    end
                end
            end
            default: begin
                st_reg <= ST_IDLE;
            end
        endcase
    end
end

// ==========================================
// Capture memory write
// No reset on the array, stale entries stay hidden by the count
always @(posedge pclk) begin
    if (cap_hit & ~k_rst & ~k_stp) begin
        mem[wp_reg[5:0]] <= cnt_reg;
    end
end

// ==========================================
// Read data register
// Loaded in the setup cycle, shown in the access phase
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rd_reg <= 32'h0000_0000;
    end else begin
        rd_reg <= 32'h0000_0000;
        if (psel & ~penable & ~pwrite) begin
            if (sel_c) begin
                rd_reg <= {21'h00_0000, ctrl_reg};
            end else if (sel_n) begin
                rd_reg <= {1'b0, high_reg, 1'b0, low_reg};
            end else if (sel_r) begin
                rd_reg <= {25'h000_0000, repc_reg};
            end else if (sel_s) begin
                rd_reg <= {9'h000, wp_reg, 1'b0, rem_reg, 4'h0, err_reg,
                           ctrl_reg[`HTPC_C_UNIT], st_reg == ST_ARM, run};
            end else if (sel_i) begin
                rd_reg <= {25'h000_0000, cidx_reg};
            end else if (sel_d) begin
                // entry at index, unwritten reads zero
                if (cidx_reg < wp_reg) begin
                    rd_reg <= {17'h0_0000, mem[cidx_reg[5:0]]};
                end
            end
        end
    end
end

// ==========================================
// Outputs
assign prdata  = rd & mapped ? rd_reg : 32'h0000_0000;
assign pready  = 1'b1;
assign pslverr = acc & ~mapped;

wire   pin_lvl = lvl_reg ^ inv;
assign pin_out = od ? 1'b0 : pin_lvl;
assign pin_oe  = drv_reg & (mode != `HTPC_MODE_CAP) & (od ? ~pin_lvl : 1'b1);

endmodule

`default_nettype wire

// file: verif/htpc_timer_asserts.sv
// Purpose: Port-level checks of the timer channel
// Assumes: One pclk domain, presetn async active low
// Notes:   Shadows invert and open-drain from CTRL writes
`timescale 1ns/1ps
`include "htpc_defs.vh"
`default_nettype none
module htpc_timer_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pin_out,
    input wire logic        pin_oe
);
    // ==========================================
    // Access decode
    wire  acc    = psel && penable;                    // Access phase
    wire  wr_cmd = acc && pwrite && paddr == `HTPC_CMD_OFS;
    wire  wr_ctl = acc && pwrite && paddr == `HTPC_CTRL_OFS;
    logic inv_q;                                       // Shadow invert
    logic od_q;                                        // Shadow open drain
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow follows CTRL writes, cleared by reset command
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inv_q <= 1'b0;
            od_q  <= 1'b0;
        end else if (wr_cmd && pwdata[`HTPC_K_RESET]) begin
            inv_q <= 1'b0;
            od_q  <= 1'b0;
        end else if (wr_ctl) begin
            inv_q <= pwdata[`HTPC_C_INV];
            od_q  <= pwdata[`HTPC_C_OD];
        end
    end
    // ==========================================
    // Properties
    chk_force_high_lvl: assert property (wr_cmd && pwdata[4:2] == 3'b010 && !od_q
        |=> pin_oe && pin_out == !inv_q) else $error("force high level wrong");
    chk_force_low_lvl: assert property (wr_cmd && pwdata[4:2] == 3'b001 && !od_q
        |=> pin_oe && pin_out == inv_q) else $error("force low level wrong");
    chk_open_drain_low: assert property (od_q |-> !pin_out)
        else $error("open drain drives high");
    chk_reset_cmd_idle: assert property (wr_cmd && pwdata[`HTPC_K_RESET]
        |=> !pin_oe && !pin_out) else $error("reset command left pin driven");
    chk_unmapped_err: assert property (acc && paddr >= 12'h01C |-> pslverr)
        else $error("unmapped access without error");
    chk_idle_no_err: assert property (!acc |-> !pslverr)
        else $error("error outside access");
    chk_rdata_gated: assert property (!(acc && !pwrite) |-> prdata == 32'h0000_0000)
        else $error("read data outside read access");
    chk_cmd_reads_zero: assert property (acc && !pwrite && paddr == `HTPC_CMD_OFS
        |-> prdata == 32'h0000_0000) else $error("command register read nonzero");
    chk_ready_always: assert property (pready)
        else $error("ready low");
endmodule
bind htpc_timer htpc_timer_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// file: verif/htpc_pin_model.sv
// Purpose: Load and signal source on the timer pin
// Assumes: Pin has a pull-up
// Notes:   Source only pulls low, so it never fights a released pin
`timescale 1ns/1ps
`default_nettype none
module htpc_pin_model (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic src_lvl,
    output var  logic pin_in
);
    // ==========================================
    // Wired level of the pin
    // pull-up when released
    always_comb pin_in = (pin_oe ? pin_out : 1'b1) & src_lvl;
endmodule
`default_nettype wire

// file: verif/htpc_timer_test.sv
// Purpose: Self-checking bench of the timer channel
// Assumes: 10 MHz pclk, ms tick shortened to 20 cycles
// Notes:   Pin source is driven through the pin model
`timescale 1ns/1ps
`include "htpc_defs.vh"
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("Error at %0t: got %h exp %h", $time, a, e); end end
module htpc_timer_test;
    // ==========================================
    // Signals
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        first_start = 0, src_lvl = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rdat;
    logic        rerr;
    wire  [31:0] prdata;
    wire         pready, pslverr, pin_out, pin_oe, pin_in;
    int          err_total = 0, num_checks = 0, n;
    htpc_timer #(.MS_DIV(14'h0014)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .first_start(first_start), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));
    htpc_pin_model u_pin (.pin_out(pin_out), .pin_oe(pin_oe), .src_lvl(src_lvl),
        .pin_in(pin_in));
    initial forever #50 pclk = ~pclk;
    // ==========================================
    // Shared tasks
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task meas(input logic v, output int k);
        k = 0;
        while (pin_out === v && k < 1000) begin
            @(negedge pclk);
            k++;
        end
    endtask
    task drive(input logic v, input int k);
        @(posedge pclk);
        src_lvl <= v;
        repeat (k) @(posedge pclk);
    endtask
    // ==========================================
    // Scenarios
    task t_resets;
        logic [11:0] a [6] = '{`HTPC_CTRL_OFS, `HTPC_COUNT_OFS, `HTPC_REPC_OFS,
                               `HTPC_CMD_OFS, `HTPC_STAT_OFS, `HTPC_CIDX_OFS};
        logic [31:0] e [6] = '{32'h0000_0000, 32'h0001_0001, 32'h0000_0000,
                               32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
        for (int i = 0; i < 6; i++) begin
            xfer(1'b0, a[i], 32'h0000_0000);
            `CHK(rdat, e[i]);
        end
        xfer(1'b0, 12'h01C, 32'h0000_0000);
        `CHK({rerr, rdat}, {1'b1, 32'h0000_0000});
        xfer(1'b1, 12'h01C, 32'h0000_0000);
        `CHK(rerr, 1'b1);
        xfer(1'b0, `HTPC_STAT_OFS, 32'h0000_0000);
        `CHK(rdat[3], 1'b1);
        xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0010);
        xfer(1'b0, `HTPC_STAT_OFS, 32'h0000_0000);
        `CHK(rdat[3], 1'b0);
    endtask
    task t_count;
        logic [31:0] bad [3] = '{32'h0001_0000, 32'h0001_7FFC, 32'h0002_7FFB};
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, `HTPC_COUNT_OFS, bad[i]);
            xfer(1'b0, `HTPC_COUNT_OFS, 32'h0000_0000);
            `CHK(rdat, 32'h0001_0001);
            xfer(1'b0, `HTPC_STAT_OFS, 32'h0000_0000);
            `CHK(rdat[3], 1'b1);
            xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0020);
        end
        xfer(1'b1, `HTPC_COUNT_OFS, 32'h0001_7FFB);
        xfer(1'b1, `HTPC_CTRL_OFS, 32'h0000_0001);
        xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0001);
        xfer(1'b1, `HTPC_COUNT_OFS, 32'h0003_0002);
        xfer(1'b0, `HTPC_COUNT_OFS, 32'h0000_0000);
        `CHK(rdat, 32'h0001_7FFB);
        xfer(1'b0, `HTPC_STAT_OFS, 32'h0000_0000);
        `CHK(rdat[3], 1'b1);
    endtask
    task t_pwm;
        for (int u = 0; u < 2; u++) begin
            xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0010);
            xfer(1'b1, `HTPC_COUNT_OFS, 32'h0003_0002);
            xfer(1'b1, `HTPC_CTRL_OFS, {29'h0, u[0], 2'h1});
            xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0001);
            xfer(1'b0, `HTPC_STAT_OFS, 32'h0000_0000);
            `CHK(rdat[2:0], {u[0], 2'b01});
            n = 0;
            while (pin_out !== 1'b1 && n < 200) begin
                @(negedge pclk);
                n++;
            end
            meas(1'b1, n);
            `CHK(n, 30 * (u + 1));
            meas(1'b0, n);
            `CHK(n, 20 * (u + 1));
            meas(1'b1, n);
            `CHK(n, 30 * (u + 1));
            xfer(1'b1, `HTPC_CTRL_OFS, {27'h0, 1'b1, 1'b0, u[0], 2'h1});
            @(negedge pclk);
            `CHK(pin_out, 1'b1);
        end
    endtask
    task t_force;
        xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0010);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, `HTPC_CTRL_OFS, {27'h0, i[1], 4'h0});
            xfer(1'b1, `HTPC_CMD_OFS, i[0] ? 32'h0000_0008 : 32'h0000_0004);
            @(negedge pclk);
            `CHK({pin_oe, pin_out}, {1'b1, i[0] ^ i[1]});
        end
        xfer(1'b1, `HTPC_CTRL_OFS, 32'h0000_0008);
        xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0008);
        @(negedge pclk);
        `CHK({pin_oe, pin_out, pin_in}, 3'b001);
        xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0004);
        @(negedge pclk);
        `CHK({pin_oe, pin_out, pin_in}, 3'b100);
    endtask
    task t_first;
        xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0010);
        xfer(1'b1, `HTPC_CTRL_OFS, 32'h0000_0181);
        xfer(1'b0, `HTPC_CTRL_OFS, 32'h0000_0000);
        `CHK(rdat, 32'h0000_0000);
        xfer(1'b1, `HTPC_CTRL_OFS, 32'h0000_0081);
        xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0001);
        xfer(1'b0, `HTPC_STAT_OFS, 32'h0000_0000);
        `CHK(rdat[1:0], 2'b10);
        @(posedge pclk);
        first_start <= 1'b1;
        @(posedge pclk);
        first_start <= 1'b0;
        xfer(1'b0, `HTPC_STAT_OFS, 32'h0000_0000);
        `CHK({pin_oe, rdat[1:0]}, 3'b101);
        xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0002);
        xfer(1'b0, `HTPC_STAT_OFS, 32'h0000_0000);
        `CHK({pin_oe, rdat[1:0]}, 3'b100);
    endtask
    task t_capture;
        logic [31:0] cap [3] = '{32'h0000_000A, 32'h0000_0015, 32'h0000_0000};
        xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0010);
        xfer(1'b1, `HTPC_CTRL_OFS, 32'h0000_0002);
        xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0001);
        xfer(1'b0, `HTPC_STAT_OFS, 32'h0000_0000);
        `CHK({rdat[14:8], rdat[0]}, {7'h40, 1'b1});
        xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0010);
        src_lvl <= 1'b0;
        xfer(1'b1, `HTPC_REPC_OFS, 32'h0000_0002);
        xfer(1'b1, `HTPC_CTRL_OFS, 32'h0000_0342);
        xfer(1'b1, `HTPC_CMD_OFS, 32'h0000_0001);
        xfer(1'b0, `HTPC_STAT_OFS, 32'h0000_0000);
        `CHK(rdat[1:0], 2'b10);
        drive(1'b1, 105);
        drive(1'b0, 50);
        drive(1'b1, 55);
        drive(1'b0, 20);
        xfer(1'b0, `HTPC_STAT_OFS, 32'h0000_0000);
        `CHK({rdat[22:16], rdat[14:8], rdat[0]}, {7'h02, 7'h00, 1'b0});
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, `HTPC_CIDX_OFS, i);
            xfer(1'b0, `HTPC_CDAT_OFS, 32'h0000_0000);
            `CHK(rdat, cap[i]);
        end
        src_lvl <= 1'b1;
    endtask
    // ==========================================
    // Verdict, main sequence and watchdog
    task end_of_test;
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_resets;
        t_count;
        t_pwm;
        t_force;
        t_first;
        t_capture;
        end_of_test;
    end
    initial begin
        #3_000_000;
        err_total++;
        end_of_test;
    end
endmodule
`default_nettype wire
